/* File: pcp_host.sv */
/*
 Host model that drives the enable/program pin of the LED programmer.
 Assumes clk is the device clock and that time is counted in clk cycles.
*/
`timescale 1ns/1ps
module pcp_host
	import pcp_pkg::*;
#(
	parameter int GAP  = 250,
	parameter int REST = 600
)
(
	input  wire logic clk,
	output logic      prog_pin
);
	initial prog_pin = 1'b0;

	// Returns just after an edge, so callers never sample on the edge.
	task automatic drv(input logic v, input int n);
		@(posedge clk);
		#1 prog_pin = v;
		repeat (n - 1) @(posedge clk);
		#1;
	endtask

	// Each half sits just above the shortest legal width and well below
	// the shortened phase-end count of the bench.
	task automatic pulses(input int n);
		repeat (n)
		begin
			drv(1'b0, PULSE_MIN_CYC + 2);
			drv(1'b1, PULSE_MIN_CYC + 2);
		end
	endtask

	// The gap after the address ends the phase but stays in the data
	// window; the rest after the data outlasts the data timeout.
	task automatic write(input int a, input int d);
		pulses(a);
		drv(1'b1, GAP);
		pulses(d);
		drv(1'b1, REST);
	endtask
endmodule

/* File: pcp_pkg.sv */
/*
 Constants, register layout and timing counts for the pulse-count LED
 current programmer. Assumes a 125 MHz system clock.
*/
package pcp_pkg;
	localparam int CLK_MHZ             = 125;
	localparam int PULSE_MIN_NS        = 200;
	localparam int PULSE_MIN_CYC       = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_MAX_US        = 100;
	localparam int PULSE_MAX_CYC       = PULSE_MAX_US * CLK_MHZ;
	localparam int DATA_TIMEOUT_US     = 1000;
	localparam int DATA_TIMEOUT_CYC    = DATA_TIMEOUT_US * CLK_MHZ;
	localparam int SHDN_US             = 1500;
	localparam int SHDN_CYC            = SHDN_US * CLK_MHZ;
	localparam int FILTER_US           = 400;
	localparam int FILTER_CYC          = FILTER_US * CLK_MHZ;
	localparam int REG_COUNT           = 6;
	localparam int LEVEL_W             = 4;
	localparam logic [3:0] LEVEL_RESET = 4'h0;
	localparam int RANGE_BIT           = 3;
	localparam int BANK_A_BIT          = 2;
	localparam int BANK_B_BIT          = 1;
	localparam int BANK_C_BIT          = 0;
	localparam logic [2:0] SEL_RANGE   = 3'h1;
	localparam logic [2:0] SEL_GLOBAL  = 3'h2;
	localparam logic [2:0] SEL_BANK_A  = 3'h3;
	localparam logic [2:0] SEL_BANK_B  = 3'h4;
	localparam logic [2:0] SEL_BANK_C  = 3'h5;
	localparam logic [2:0] SEL_LOCK    = 3'h6;
	typedef enum logic [1:0] {PCP_G1X, PCP_G133, PCP_G15, PCP_G2X} pcp_gain_t;
	typedef enum {PCP_IDLE, PCP_ADDR, PCP_WAIT, PCP_DATA} pcp_state_t;
endpackage

/* File: pcp_programmer.sv */
/*
 Control logic of a six-channel LED driver programmed over one
 enable/program pin. Assumes the undervoltage flag and the pump regulation
 flags are synchronous to clk; the pin is synchronised here; reset_n is power-on reset.
*/
`timescale 1ns/1ps
module pcp_programmer
	import pcp_pkg::*;
#(
	parameter int DATA_TIMEOUT = DATA_TIMEOUT_CYC,
	parameter int SHDN_TIME    = SHDN_CYC,
	parameter int FILTER_TIME  = FILTER_CYC,
	parameter int PULSE_MAX    = PULSE_MAX_CYC
)
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        prog_pin,
	input  wire logic        undervoltage,
	input  wire logic        reg_insufficient,
	input  wire logic        unity_sufficient,
	output logic             device_enabled,
	output logic             led_sink_outputs_hiz,
	output logic             current_range_select,
	output logic [2:0]       bank_on,
	output logic [3:0]       global_level,
	output logic [3:0]       bank_a_level,
	output logic [3:0]       bank_b_level,
	output logic [3:0]       bank_c_level,
	output logic             pump_return_lock_bit,
	output pcp_gain_t        pump_gain
);
	// The phase-end count must stay below the data timeout, or every
	// address would time out before the data window opens.
	if (DATA_TIMEOUT <= PULSE_MAX || SHDN_TIME < 2 || FILTER_TIME < 1
		|| PULSE_MAX < 2)
	begin : g_bad_timing
		$error("pcp_programmer: timing parameters out of range");
	end

	logic       pin_s1_reg;
	logic       pin_reg;
	logic       pin_d_reg;
	logic       en_reg;
	logic       fall;
	logic       rise;
	logic       clear_all;
	logic [31:0] low_cnt_reg;
	logic [31:0] tmr_reg;
	logic [31:0] flt_reg;
	logic [2:0] addr_reg;
	logic [4:0] pulses_reg;
	logic [3:0] bank_on_and_range_reg;
	logic [3:0] global_current_level_reg;
	logic [3:0] bank_a_current_level_reg;
	logic [3:0] bank_b_current_level_reg;
	logic [3:0] bank_c_current_level_reg;
	logic       pump_return_lock_reg;
	pcp_state_t state_reg;
	pcp_gain_t  gain_reg;

	// Three flops; only the second and third feed the edge detectors.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_s1_reg <= 1'b0;
			pin_reg    <= 1'b0;
			pin_d_reg  <= 1'b0;
		end
		else
		begin
			pin_s1_reg <= prog_pin;
			pin_reg    <= pin_s1_reg;
			pin_d_reg  <= pin_reg;
		end
	end

	assign fall = pin_d_reg & ~pin_reg;
	assign rise = ~pin_d_reg & pin_reg;

	// Long-low detector. Registers are lost at shutdown entry.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			low_cnt_reg <= '0;
		else if (pin_reg)
			low_cnt_reg <= '0;
		else if (low_cnt_reg < 32'(SHDN_TIME))
			low_cnt_reg <= low_cnt_reg + 32'd1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			en_reg <= 1'b0;
		else if (rise)
			en_reg <= 1'b1;
		else if (low_cnt_reg == 32'(SHDN_TIME - 1))
			en_reg <= 1'b0;
	end

	assign clear_all = undervoltage || !en_reg;

	// Address/data sequencer. A pulse narrower than one clock may slip
	// past the synchroniser unseen; such pulses are below legal width.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg  <= PCP_IDLE;
			addr_reg   <= 3'h0;
			pulses_reg <= 5'h00;
			tmr_reg    <= '0;
		end
		else if (clear_all)
		begin
			state_reg  <= PCP_IDLE;
			addr_reg   <= 3'h0;
			pulses_reg <= 5'h00;
			tmr_reg    <= '0;
		end
		else
		begin
			tmr_reg <= (fall || rise) ? '0 : tmr_reg + 32'd1;
			unique case (state_reg)
				PCP_IDLE:
					if (fall)
					begin
						state_reg <= PCP_ADDR;
						addr_reg  <= 3'h1;
					end
				PCP_ADDR:
					if (fall)
						addr_reg <= (addr_reg < 3'(REG_COUNT)) ?
							addr_reg + 3'h1 : addr_reg;
					else if (pin_reg && tmr_reg >= 32'(PULSE_MAX))
					begin
						state_reg  <= PCP_WAIT;
						pulses_reg <= 5'h00;
					end
				PCP_WAIT:
					if (fall)
					begin
						state_reg  <= PCP_DATA;
						pulses_reg <= 5'h01;
					end
					else if (tmr_reg >= 32'(DATA_TIMEOUT))
						state_reg <= PCP_IDLE;
				PCP_DATA:
					if (fall)
						pulses_reg <= pulses_reg + 5'h01;
					else if (pin_reg && tmr_reg >= 32'(PULSE_MAX))
						state_reg <= PCP_IDLE;
			endcase
		end
	end

	// Select clears the register; data value is 16 minus pulses.
	function automatic logic [3:0] level_of(input logic [4:0] n);
		level_of = 4'(5'h10 - n);
	endfunction

	logic       wr_sel;
	logic [3:0] wr_val;
	assign wr_sel = (state_reg == PCP_ADDR && pin_reg
		&& tmr_reg >= 32'(PULSE_MAX) && !fall) || state_reg == PCP_DATA;
	assign wr_val = (state_reg == PCP_DATA) ? level_of(pulses_reg)
		: LEVEL_RESET;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bank_on_and_range_reg    <= LEVEL_RESET;
			global_current_level_reg <= LEVEL_RESET;
			bank_a_current_level_reg <= LEVEL_RESET;
			bank_b_current_level_reg <= LEVEL_RESET;
			bank_c_current_level_reg <= LEVEL_RESET;
			pump_return_lock_reg     <= 1'b0;
		end
		else if (clear_all)
		begin
			bank_on_and_range_reg    <= LEVEL_RESET;
			global_current_level_reg <= LEVEL_RESET;
			bank_a_current_level_reg <= LEVEL_RESET;
			bank_b_current_level_reg <= LEVEL_RESET;
			bank_c_current_level_reg <= LEVEL_RESET;
			pump_return_lock_reg     <= 1'b0;
		end
		else if (wr_sel)
		begin
			unique case (addr_reg)
				SEL_RANGE:  bank_on_and_range_reg    <= wr_val;
				SEL_GLOBAL: global_current_level_reg <= wr_val;
				SEL_BANK_A: bank_a_current_level_reg <= wr_val;
				SEL_BANK_B: bank_b_current_level_reg <= wr_val;
				SEL_BANK_C: bank_c_current_level_reg <= wr_val;
				SEL_LOCK:   pump_return_lock_reg <=
					(state_reg == PCP_DATA) && pulses_reg == 5'h01;
				default: ;
			endcase
		end
	end

	// Gain sequencer with insufficiency filter.
	logic lock_reset;
	assign lock_reset = wr_sel && state_reg == PCP_ADDR
		&& addr_reg == SEL_LOCK;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gain_reg <= PCP_G1X;
			flt_reg  <= '0;
		end
		else if (clear_all || lock_reset)
		begin
			gain_reg <= PCP_G1X;
			flt_reg  <= '0;
		end
		else if (gain_reg != PCP_G1X && unity_sufficient
			&& !pump_return_lock_reg)
		begin
			gain_reg <= PCP_G1X;
			flt_reg  <= '0;
		end
		else if (!reg_insufficient || gain_reg == PCP_G2X)
			flt_reg <= '0;
		else if (flt_reg >= 32'(FILTER_TIME - 1))
		begin
			flt_reg <= '0;
			unique case (gain_reg)
				PCP_G1X:  gain_reg <= PCP_G133;
				PCP_G133: gain_reg <= PCP_G15;
				PCP_G15:  gain_reg <= PCP_G2X;
				PCP_G2X:  gain_reg <= PCP_G2X;
			endcase
		end
		else
			flt_reg <= flt_reg + 32'd1;
	end

	// Range bit 0 means the analog stage divides by eight.
	assign device_enabled       = en_reg;
	assign led_sink_outputs_hiz = !en_reg;
	assign current_range_select = bank_on_and_range_reg[RANGE_BIT];
	assign bank_on = {bank_on_and_range_reg[BANK_A_BIT],
		bank_on_and_range_reg[BANK_B_BIT],
		bank_on_and_range_reg[BANK_C_BIT]};
	assign global_level         = global_current_level_reg;
	assign bank_a_level         = bank_a_current_level_reg;
	assign bank_b_level         = bank_b_current_level_reg;
	assign bank_c_level         = bank_c_current_level_reg;
	assign pump_return_lock_bit = pump_return_lock_reg;
	assign pump_gain            = gain_reg;

	a_shdn_clears: assert property (
		@(posedge clk) disable iff (!reset_n)
		!en_reg |-> ##1 (bank_on_and_range_reg == 4'h0))
		else $error("registers not cleared in shutdown");
	a_uv_clears: assert property (
		@(posedge clk) disable iff (!reset_n)
		undervoltage |=> bank_on == 3'h0)
		else $error("undervoltage left a bank on");
	a_no_skip_up: assert property (
		@(posedge clk) disable iff (!reset_n)
		(gain_reg == PCP_G1X && $past(gain_reg) != PCP_G1X) or
		(gain_reg == $past(gain_reg)) or
		(gain_reg == pcp_gain_t'($past(gain_reg) + 2'd1)))
		else $error("gain skipped a step");
	a_lock_holds: assert property (
		@(posedge clk) disable iff (!reset_n)
		(pump_return_lock_reg && gain_reg != PCP_G1X && !clear_all
		&& !lock_reset) |=> gain_reg != PCP_G1X)
		else $error("gain dropped while locked");
	a_sel6_reset: assert property (
		@(posedge clk) disable iff (!reset_n)
		lock_reset && !clear_all |=> gain_reg == PCP_G1X)
		else $error("register six select did not reset pump");
	a_timeout_idle: assert property (
		@(posedge clk) disable iff (!reset_n)
		state_reg == PCP_WAIT && tmr_reg >= 32'(DATA_TIMEOUT) && !fall
		|=> state_reg == PCP_IDLE)
		else $error("data timeout not taken");
	a_sel_clear: assert property (
		@(posedge clk) disable iff (!reset_n)
		wr_sel && state_reg == PCP_ADDR && addr_reg == SEL_GLOBAL
		&& !clear_all |=> global_current_level_reg == 4'h0)
		else $error("selected register not cleared");
	a_first_rise: assert property (
		@(posedge clk) disable iff (!reset_n)
		rise |=> en_reg)
		else $error("rise did not enable");
	a_down_to_unity: assert property (
		@(posedge clk) disable iff (!reset_n)
		gain_reg < $past(gain_reg) |-> gain_reg == PCP_G1X)
		else $error("gain stepped down to a middle mode");
	a_addr_in_range: assert property (
		@(posedge clk) disable iff (!reset_n)
		state_reg != PCP_IDLE |-> addr_reg >= SEL_RANGE
		&& addr_reg <= SEL_LOCK)
		else $error("address count left the register range");
	a_step_needs_low: assert property (
		@(posedge clk) disable iff (!reset_n)
		gain_reg > $past(gain_reg) |-> $past(reg_insufficient))
		else $error("gain stepped up without insufficiency");
	a_long_low_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		!pin_reg && low_cnt_reg == 32'(SHDN_TIME - 1) |=> !en_reg)
		else $error("long low did not shut down");
	a_uv_idle: assert property (
		@(posedge clk) disable iff (!reset_n)
		undervoltage |=> state_reg == PCP_IDLE)
		else $error("undervoltage left the sequencer busy");
endmodule

/* File: testbench.sv */
/*
 Self-checking bench for the LED programmer with shortened counts.
 Assumes the host model drives the pin and the bench drives the rest.
*/
`timescale 1ns/1ps
module testbench;
	import pcp_pkg::*;
	localparam int TOUT = 400;
	localparam int SHDN = 600;
	localparam int PMAX = 40;
	logic       clk;
	logic       reset_n;
	logic       undervoltage;
	logic       reg_insufficient;
	logic       unity_sufficient;
	wire logic  prog_pin;
	logic       device_enabled;
	logic       led_sink_outputs_hiz;
	logic       current_range_select;
	logic [2:0] bank_on;
	logic [3:0] global_level;
	logic [3:0] bank_a_level;
	logic [3:0] bank_b_level;
	logic [3:0] bank_c_level;
	logic       pump_return_lock_bit;
	pcp_gain_t  pump_gain;
	int         miscompares = 0;
	int         n_tests = 0;

	pcp_host #(.GAP(TOUT * 5 / 8), .REST(TOUT * 3 / 2)) host (
		.clk     (clk),
		.prog_pin(prog_pin)
	);
	pcp_programmer #(
		.DATA_TIMEOUT(TOUT),
		.SHDN_TIME   (SHDN),
		.FILTER_TIME (10),
		.PULSE_MAX   (PMAX)
	) uut (
		.clk                 (clk),
		.reset_n             (reset_n),
		.prog_pin            (prog_pin),
		.undervoltage        (undervoltage),
		.reg_insufficient    (reg_insufficient),
		.unity_sufficient    (unity_sufficient),
		.device_enabled      (device_enabled),
		.led_sink_outputs_hiz(led_sink_outputs_hiz),
		.current_range_select(current_range_select),
		.bank_on             (bank_on),
		.global_level        (global_level),
		.bank_a_level        (bank_a_level),
		.bank_b_level        (bank_b_level),
		.bank_c_level        (bank_c_level),
		.pump_return_lock_bit(pump_return_lock_bit),
		.pump_gain           (pump_gain)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [3:0] get(input int a);
		case (a)
			1: return {current_range_select, bank_on};
			2: return global_level;
			3: return bank_a_level;
			4: return bank_b_level;
			5: return bank_c_level;
			default: return {3'h0, pump_return_lock_bit};
		endcase
	endfunction

	// A gain that never arrives still ends the wait and counts a mismatch.
	task automatic wait_gain(input pcp_gain_t g);
		for (int i = 0; i < 40 && pump_gain !== g; i++)
			@(posedge clk) #1;
		chk({2'h0, pump_gain}, {2'h0, g});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		reset_n = 1'b0;
		undervoltage = 1'b0;
		reg_insufficient = 1'b0;
		unity_sufficient = 1'b0;
		cyc(2);
		reset_n = 1'b1;
		chk({device_enabled, led_sink_outputs_hiz, 2'h0}, 4'h4);
		chk({2'h0, pump_gain}, 4'h0);
		for (int a = 1; a <= 6; a++)
			chk(get(a), 4'h0);
		cyc(10);
		host.drv(1'b1, 10);
		chk({device_enabled, led_sink_outputs_hiz, 2'h0}, 4'h8);
		for (int a = 1; a <= 5; a++)
		begin
			host.write(a, 3 * a);
			chk(get(a), 4'(16 - 3 * a));
		end
		host.write(1, 9);
		chk(get(1), 4'h7);
		host.write(2, 16);
		chk(get(2), 4'h0);
		host.write(3, 0);
		chk(get(3), 4'h0);
		host.pulses(4);
		host.drv(1'b1, 2 * TOUT);
		chk(get(4), 4'h0);
		host.write(5, 1);
		chk(get(5), 4'hF);
		reg_insufficient = 1'b1;
		cyc(5);
		chk({2'h0, pump_gain}, 4'h0);
		wait_gain(PCP_G133);
		wait_gain(PCP_G15);
		wait_gain(PCP_G2X);
		cyc(30);
		chk({2'h0, pump_gain}, 4'h3);
		reg_insufficient = 1'b0;
		unity_sufficient = 1'b1;
		wait_gain(PCP_G1X);
		unity_sufficient = 1'b0;
		host.write(6, 1);
		chk(get(6), 4'h1);
		reg_insufficient = 1'b1;
		wait_gain(PCP_G133);
		reg_insufficient = 1'b0;
		unity_sufficient = 1'b1;
		cyc(6);
		chk({2'h0, pump_gain}, 4'h1);
		unity_sufficient = 1'b0;
		host.write(6, 2);
		chk(get(6), 4'h0);
		chk({2'h0, pump_gain}, 4'h0);
		undervoltage = 1'b1;
		cyc(4);
		for (int a = 1; a <= 6; a++)
			chk(get(a), 4'h0);
		undervoltage = 1'b0;
		host.write(2, 1);
		chk(get(2), 4'hF);
		host.drv(1'b0, SHDN + 10);
		chk({device_enabled, led_sink_outputs_hiz, 2'h0}, 4'h4);
		chk(get(2), 4'h0);
		conclude();
	end
endmodule
